// ---- inc/rsa_pkg.sv ----
// package: strap bit positions, encodings, attribute codes and decode constants
package rsa_pkg;

  // strap positions on the display cache data bus
  localparam int unsigned BUS_W = 32;
  localparam int unsigned XOR_BIT = 31;
  localparam int unsigned ALLZ_BIT = 30;
  localparam int unsigned FSEL_BIT = 29;
  localparam int unsigned IOQ_BIT = 28;
  localparam int unsigned F133_BIT = 13;

  // host bus frequency encoding
  typedef enum logic [1:0] {
    RSA_HF_66 = 2'h0,
    RSA_HF_100 = 2'h1,
    RSA_HF_133 = 2'h2
  } rsa_hfreq_type;

  // in-order queue depth values
  localparam logic [2:0] IOQ_DEPTH_4 = 3'h4;
  localparam logic [2:0] IOQ_DEPTH_1 = 3'h1;

  // per-bit access attribute codes
  typedef enum logic [1:0] {
    RSA_ATTR_RW = 2'h0,
    RSA_ATTR_RO = 2'h1,
    RSA_ATTR_WC = 2'h2,
    RSA_ATTR_WO = 2'h3
  } rsa_attr_type;

  // attribute register width
  localparam int unsigned REG_W = 32;

  // config offset of the mmio base pointer in graphics device 1
  localparam logic [7:0] MMIO_BASE_CFG_OFS = 8'h14;
  // size of the memory window for display cache registers
  localparam int unsigned MMIO_WIN_BITS = 19;
  // io base for detect/diagnostic registers (arbitrary)
  localparam logic [15:0] DIAG_IO_BASE = 16'h03d0;
  localparam int unsigned DIAG_IO_BITS = 4;

  // captured strap options travelling as one bundle
  typedef struct packed {
    logic xor_test;
    logic all_z;
    rsa_hfreq_type host_freq;
    logic [2:0] inorder_queue_depth;
  } rsa_straps_type;

  // default strap bundle before first capture
  localparam rsa_straps_type STRAP_RST = '{1'b0, 1'b0, RSA_HF_66, IOQ_DEPTH_4};

endpackage

// ---- hdl/rsa_attr_reg.sv ----
// one attribute-governed register: ro, rw, write-one-clear, write-once per bit
`timescale 1ns/1ps
`default_nettype none
module rsa_attr_reg (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [rsa_pkg::REG_W-1:0] reset_value,
  input wire rsa_pkg::rsa_attr_type [rsa_pkg::REG_W-1:0] attr,
  input wire logic wr_en,
  input wire logic [3:0] wr_be,
  input wire logic [rsa_pkg::REG_W-1:0] wr_data,
  input wire logic [rsa_pkg::REG_W-1:0] hw_set,
  output logic [rsa_pkg::REG_W-1:0] value
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [rsa_pkg::REG_W-1:0] val_ff; // stored bits
  logic [rsa_pkg::REG_W-1:0] nxt_val;
  logic [rsa_pkg::REG_W-1:0] done_ff; // write-once used flags
  logic [rsa_pkg::REG_W-1:0] nxt_done;
  logic rst_d_ff; // reset seen last cycle, load defaults after release
  logic nxt_rst_d;

  // -------------------------------------------------------------
  // per bit next-state
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < rsa_pkg::REG_W; gi++)
    begin : g_bit
      logic we;
      assign we = wr_en && wr_be[gi/8];
      always_comb
      begin
        nxt_val[gi] = val_ff[gi];
        nxt_done[gi] = done_ff[gi];
        if (rst_d_ff)
        begin
          // default taken after reset (strap-fed bits included)
          nxt_val[gi] = reset_value[gi];
        end
        else
        begin
          unique case (attr[gi])
            rsa_pkg::RSA_ATTR_RW:
            begin
              if (we)
                nxt_val[gi] = wr_data[gi];
            end
            rsa_pkg::RSA_ATTR_RO:
            begin
              nxt_val[gi] = hw_set[gi] | val_ff[gi];
            end
            rsa_pkg::RSA_ATTR_WC:
            begin
              if (we && wr_data[gi])
                nxt_val[gi] = 1'b0;
              if (hw_set[gi])
                nxt_val[gi] = 1'b1;
            end
            rsa_pkg::RSA_ATTR_WO:
            begin
              if (we && !done_ff[gi])
              begin
                nxt_val[gi] = wr_data[gi];
                nxt_done[gi] = 1'b1;
              end
            end
          endcase
        end
      end

      // write-once bit holds after its first write
      wo_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!rst_d_ff && attr[gi] == rsa_pkg::RSA_ATTR_WO && done_ff[gi] && $stable(attr[gi]))
          |=> (val_ff[gi] == $past(val_ff[gi])))
        else $error("write-once bit changed after first write");

      // writing one to a clear bit with no set clears it
      wc_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!rst_d_ff && attr[gi] == rsa_pkg::RSA_ATTR_WC && we && wr_data[gi] && !hw_set[gi])
          |=> !val_ff[gi])
        else $error("write-one-clear bit did not clear");
    end
  endgenerate

  always_comb
  begin
    nxt_rst_d = 1'b0;
  end

  // registers only
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      val_ff <= '0;
      done_ff <= '0;
      rst_d_ff <= 1'b1;
    end
    else
    begin
      val_ff <= nxt_val;
      done_ff <= nxt_done;
      rst_d_ff <= nxt_rst_d;
    end
  end

  assign value = val_ff;

endmodule
`default_nettype wire

// ---- hdl/rsa_strap_loader.sv ----
// strap capture, derived options, attribute register and address decode
`timescale 1ns/1ps
`default_nettype none
module rsa_strap_loader (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [rsa_pkg::BUS_W-1:0] display_cache_data_bus,
  input wire logic processor_reset_line,
  input wire logic [31:0] mmio_base_pointer,
  input wire logic acc_valid,
  input wire logic acc_is_io,
  input wire logic [31:0] acc_addr,
  input wire logic acc_write,
  input wire logic [3:0] acc_be,
  input wire logic [31:0] acc_wdata,
  input wire rsa_pkg::rsa_attr_type [rsa_pkg::REG_W-1:0] reg_attr,
  input wire logic [rsa_pkg::REG_W-1:0] hw_event,
  output rsa_pkg::rsa_straps_type straps,
  output logic xor_tree_mode,
  output logic all_outputs_z,
  output logic dc_reg_hit,
  output logic diag_reg_hit,
  output logic [31:0] reg_value
);

  // -------------------------------------------------------------
  // strap capture state
  // -------------------------------------------------------------
  rsa_pkg::rsa_straps_type straps_ff; // held options
  rsa_pkg::rsa_straps_type nxt_straps;
  logic prst_d_ff; // delayed processor reset line
  logic nxt_prst_d;
  rsa_pkg::rsa_hfreq_type freq_dec; // decoded frequency

  // frequency decode from the bus
  // bit13 outranks bit29, so a 133 strap ignores the 66/100 pin
  always_comb
  begin
    if (display_cache_data_bus[rsa_pkg::F133_BIT])
      freq_dec = rsa_pkg::RSA_HF_133;
    else if (display_cache_data_bus[rsa_pkg::FSEL_BIT])
      freq_dec = rsa_pkg::RSA_HF_100;
    else
      freq_dec = rsa_pkg::RSA_HF_66;
  end

  // next strap values
  always_comb
  begin
    nxt_straps = straps_ff;
    // delayed copy for the rise detector
    nxt_prst_d = processor_reset_line;
    if (sys_rst)
    begin
      nxt_straps.xor_test = display_cache_data_bus[rsa_pkg::XOR_BIT];
      nxt_straps.all_z = display_cache_data_bus[rsa_pkg::ALLZ_BIT];
      nxt_straps.host_freq = freq_dec;
    end
    // processor reset may rise inside or after cold reset, so no priority
    if (processor_reset_line && !prst_d_ff)
    begin
      nxt_straps.inorder_queue_depth = display_cache_data_bus[rsa_pkg::IOQ_BIT] ?
        rsa_pkg::IOQ_DEPTH_1 : rsa_pkg::IOQ_DEPTH_4;
    end
  end

  // registers only; capture is a clocked load, not an async preset
  always_ff @(posedge clock)
  begin
    straps_ff <= nxt_straps;
    prst_d_ff <= nxt_prst_d;
  end

  // -------------------------------------------------------------
  // strap outputs, all from flops
  // -------------------------------------------------------------
  assign straps = straps_ff;
  assign xor_tree_mode = straps_ff.xor_test;
  assign all_outputs_z = straps_ff.all_z;

  // -------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------
  logic mem_in_win;
  logic io_in_win;
  assign mem_in_win = !acc_is_io &&
    (acc_addr[31:rsa_pkg::MMIO_WIN_BITS] == mmio_base_pointer[31:rsa_pkg::MMIO_WIN_BITS]);
  assign io_in_win = acc_is_io &&
    (acc_addr[15:rsa_pkg::DIAG_IO_BITS] == rsa_pkg::DIAG_IO_BASE[15:rsa_pkg::DIAG_IO_BITS]);
  // the memory window serves both register sets
  assign dc_reg_hit = acc_valid && mem_in_win;
  assign diag_reg_hit = acc_valid && (io_in_win || mem_in_win);

  // -------------------------------------------------------------
  // attribute register, defaults partly from straps
  // -------------------------------------------------------------
  logic [31:0] reset_val;
  // upper 28 bits of the default word are zero
  assign reset_val = {28'h0000000, straps_ff.xor_test, straps_ff.all_z,
    straps_ff.host_freq};

  // writes reach the register only through a decoded hit
  rsa_attr_reg u_reg (
    .clock(clock),
    .sys_rst(sys_rst),
    .reset_value(reset_val),
    .attr(reg_attr),
    .wr_en(acc_write && diag_reg_hit),
    .wr_be(acc_be),
    .wr_data(acc_wdata),
    .hw_set(hw_event),
    .value(reg_value)
  );

  // -------------------------------------------------------------
  // checks on strap capture and decode
  // -------------------------------------------------------------
  // depth follows bit28 at the rise
  ioq_cap_a: assert property (@(posedge clock)
    (processor_reset_line && !prst_d_ff) |=> (straps_ff.inorder_queue_depth ==
      ($past(display_cache_data_bus[rsa_pkg::IOQ_BIT]) ? rsa_pkg::IOQ_DEPTH_1
        : rsa_pkg::IOQ_DEPTH_4)))
    else $error("queue depth not captured");

  // depth only moves at a rise
  ioq_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(processor_reset_line && !prst_d_ff) |=> $stable(straps_ff.inorder_queue_depth))
    else $error("queue depth moved without a rise");

  // cold-reset straps stay put outside reset
  strap_hold_a: assert property (@(posedge clock)
    (!sys_rst && !$past(sys_rst)) |-> $stable(straps_ff.host_freq) && $stable(straps_ff.all_z)
      && $stable(straps_ff.xor_test))
    else $error("strap value moved outside reset");

  // 133 selected when bit13 high in reset
  freq_133_a: assert property (@(posedge clock)
    (sys_rst && display_cache_data_bus[rsa_pkg::F133_BIT]) |=>
      straps_ff.host_freq == rsa_pkg::RSA_HF_133)
    else $error("133 MHz not selected");

  freq_low_a: assert property (@(posedge clock)
    (sys_rst && !display_cache_data_bus[rsa_pkg::F133_BIT]) |=> straps_ff.host_freq ==
      ($past(display_cache_data_bus[rsa_pkg::FSEL_BIT]) ? rsa_pkg::RSA_HF_100
        : rsa_pkg::RSA_HF_66))
    else $error("66/100 MHz decode wrong");

  xor_mode_a: assert property (@(posedge clock)
    sys_rst |=> xor_tree_mode == $past(display_cache_data_bus[rsa_pkg::XOR_BIT]))
    else $error("xor mode mismatch");

  all_z_a: assert property (@(posedge clock)
    sys_rst |=> all_outputs_z == $past(display_cache_data_bus[rsa_pkg::ALLZ_BIT]))
    else $error("all-z mismatch");

  // defaults loaded at the first edge after release, checked at the second
  dflt_load_a: assert property (@(posedge clock)
    ($past(sys_rst, 2) && !$past(sys_rst) && !sys_rst && !$past(hw_event[1]))
      |-> reg_value[1:0] == straps_ff.host_freq)
    else $error("default not loaded");

  io_hit_a: assert property (@(posedge clock)
    (acc_valid && acc_is_io && (acc_addr[15:rsa_pkg::DIAG_IO_BITS] ==
      rsa_pkg::DIAG_IO_BASE[15:rsa_pkg::DIAG_IO_BITS])) |-> diag_reg_hit && !dc_reg_hit)
    else $error("io diagnostic decode wrong");

  // memory access in the window hits both sets
  mem_hit_a: assert property (@(posedge clock)
    (acc_valid && !acc_is_io && (acc_addr[31:rsa_pkg::MMIO_WIN_BITS] ==
      mmio_base_pointer[31:rsa_pkg::MMIO_WIN_BITS])) |-> dc_reg_hit && diag_reg_hit)
    else $error("memory window decode wrong");

  // strap select bits in the default word
  dflt_bits_a: assert property (@(posedge clock)
    ($past(sys_rst, 2) && !$past(sys_rst) && !sys_rst)
      |-> reg_value[3:2] == {straps_ff.xor_test, straps_ff.all_z})
    else $error("strap selects missing from default");

  // only the three legal host frequencies
  freq_legal_a: assert property (@(posedge clock) disable iff (sys_rst)
    straps_ff.host_freq inside {rsa_pkg::RSA_HF_66, rsa_pkg::RSA_HF_100, rsa_pkg::RSA_HF_133})
    else $error("illegal host frequency code");

endmodule
`default_nettype wire

// ---- tb/rsa_strap_board.sv ----
// board strap resistor model on the display cache data bus
`timescale 1ns/1ps
`default_nettype none
module rsa_strap_board (
  input wire logic sys_rst,
  input wire logic [31:0] strap_set,
  output logic [31:0] display_cache_data_bus
);
  // ------------------------------
  // strap drive
  // ------------------------------
  // test strap held, others only in reset
  // outside reset the bus carries memory traffic, modelled as inverted bits
  assign display_cache_data_bus = sys_rst ? strap_set : {strap_set[31], ~strap_set[30:0]};
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the strap loader and attribute register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock;
  logic sys_rst;
  logic [31:0] strap_set;
  logic [31:0] bus;
  logic processor_reset_line;
  logic [31:0] mmio_base;
  logic acc_valid;
  logic acc_is_io;
  logic [31:0] acc_addr;
  logic acc_write;
  logic [3:0] acc_be;
  logic [31:0] acc_wdata;
  rsa_pkg::rsa_attr_type [31:0] reg_attr;
  logic [31:0] hw_event;
  rsa_pkg::rsa_straps_type straps;
  logic xor_m;
  logic allz;
  logic dc_hit;
  logic diag_hit;
  logic [31:0] reg_value;
  int failures;
  int checked;
  logic [31:0] pats [5] = '{32'hc000_2000, 32'h3000_0000, 32'h2000_2000, 32'h1000_2000, 32'h0};

  rsa_strap_board i_rsa_strap_board (.sys_rst(sys_rst), .strap_set(strap_set),
    .display_cache_data_bus(bus));
  rsa_strap_loader i_rsa_strap_loader (.clock(clock), .sys_rst(sys_rst),
    .display_cache_data_bus(bus), .processor_reset_line(processor_reset_line),
    .mmio_base_pointer(mmio_base), .acc_valid(acc_valid), .acc_is_io(acc_is_io),
    .acc_addr(acc_addr), .acc_write(acc_write), .acc_be(acc_be), .acc_wdata(acc_wdata),
    .reg_attr(reg_attr), .hw_event(hw_event), .straps(straps), .xor_tree_mode(xor_m),
    .all_outputs_z(allz), .dc_reg_hit(dc_hit), .diag_reg_hit(diag_hit), .reg_value(reg_value));

  // ------------------------------
  // checking and verdict
  // ------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  // cold reset with a strap pattern, processor reset rising inside it
  task automatic t_reset(input logic [31:0] pat);
    logic [1:0] hf;
    hf = pat[13] ? 2'h2 : {1'b0, pat[29]};
    @(posedge clock);
    strap_set <= pat;
    sys_rst <= 1'b1;
    processor_reset_line <= 1'b0;
    repeat (2) @(posedge clock);
    processor_reset_line <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    // bus now inverted, values must hold
    chk(32'(straps.host_freq), 32'(hf));
    chk({31'h0, xor_m}, {31'h0, pat[31]});
    chk({31'h0, allz}, {31'h0, pat[30]});
    chk(32'(straps.inorder_queue_depth), pat[28] ? 32'h1 : 32'h4);
    chk(reg_value, {28'h0, pat[31], pat[30], hf});
  endtask

  // one write access; decode checked while it is presented
  task automatic acc(input logic io, input logic [31:0] a, input logic [3:0] be,
    input logic [31:0] wd, input logic hit);
    @(posedge clock);
    acc_valid <= 1'b1;
    acc_is_io <= io;
    acc_addr <= a;
    acc_write <= 1'b1;
    acc_be <= be;
    acc_wdata <= wd;
    @(negedge clock);
    chk({31'h0, diag_hit}, {31'h0, hit});
    chk({31'h0, dc_hit}, {31'h0, hit & ~io});
    @(posedge clock);
    acc_valid <= 1'b0;
    acc_write <= 1'b0;
    @(negedge clock);
  endtask

  // bytes: 0 ro, 1 write-one-clear, 2 write-once, 3 rw
  task automatic t_attr;
    @(posedge clock);
    hw_event <= 32'h0000_ff00;
    @(posedge clock);
    hw_event <= 32'h0;
    @(negedge clock);
    chk(reg_value, 32'h0000_ff00);
    acc(1'b0, 32'h1238_0010, 4'hf, 32'h5a5a_0f5a, 1'b1);
    chk(reg_value, 32'h5a5a_f000);
    acc(1'b1, 32'h0000_03d4, 4'hf, 32'ha5a5_ffa5, 1'b1);
    chk(reg_value, 32'ha55a_0000);
    acc(1'b0, 32'h1230_0010, 4'hf, 32'h0, 1'b0);
    chk(reg_value, 32'ha55a_0000);
    acc(1'b1, 32'h0000_03e0, 4'hf, 32'h0, 1'b0);
    chk(reg_value, 32'ha55a_0000);
    acc(1'b0, 32'h1238_0000, 4'h8, 32'h3c3c_3c3c, 1'b1);
    chk(reg_value, 32'h3c5a_0000);
  endtask

  // ------------------------------
  // clock, stimulus, watchdog
  // ------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    #200000;
    failures++;
    test_done();
  end

  initial
  begin
    sys_rst = 1'b1;
    strap_set = 32'h0;
    processor_reset_line = 1'b0;
    mmio_base = 32'h1238_0000;
    acc_valid = 1'b0;
    acc_is_io = 1'b0;
    acc_addr = 32'h0;
    acc_write = 1'b0;
    acc_be = 4'h0;
    acc_wdata = 32'h0;
    hw_event = 32'h0;
    for (int i = 0; i < 32; i++)
      reg_attr[i] = rsa_pkg::rsa_attr_type'(i < 24 ? (i / 8) + 1 : 0);
    repeat (4) @(posedge clock);
    foreach (pats[k])
      t_reset(pats[k]);
    t_attr();
    test_done();
  end
endmodule
`default_nettype wire
